/* core/drsch_pkg.sv */
package drsch_pkg;
  // Clock period in picoseconds (250 MHz)
  localparam int CLK_PERIOD_PS = 4000;
  // Printed intervals in nanoseconds
  localparam int BASE_INTERVAL_NS = 7800;
  localparam int EXT_INTERVAL_NS = 3900;
  localparam int HOT_INTERVAL_NS = 1950;
  localparam int VHOT_INTERVAL_NS = 975;
  // All intervals round down to whole cycles
  localparam int BASE_INTERVAL_CYC = BASE_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
  localparam int EXT_INTERVAL_CYC = EXT_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
  localparam int HOT_INTERVAL_CYC = HOT_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
  localparam int VHOT_INTERVAL_CYC = VHOT_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
  // Refresh cycle time defaults per density, in ns (cycle counts round up)
  localparam int RFC_2G_NS = 160;
  localparam int RFC_4G_NS = 260;
  localparam int RFC_8G_NS = 350;
  localparam int RFC_2G_CYC = (RFC_2G_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_4G_CYC = (RFC_4G_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RFC_8G_CYC = (RFC_8G_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Precharge time before a refresh
  localparam int RP_NS = 14;
  localparam int RP_CYC = (RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Debt limits in 1x units, scaled by mode
  localparam int POSTPONE_1X = 8;
  localparam int PULLIN_1X = 8;
  localparam int BURST_1X = 16;
  localparam int BURST_WIN_1X = 2;
  localparam int DEBT_W = 8;
  localparam int CNT_W = 16;
  // Register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_TEMP_LO = 3;
  localparam int CTRL_TCR_EN = 5;
  localparam int CTRL_TCR_EXT = 6;
  localparam int CTRL_DENS_LO = 7;
  localparam int CTRL_PULLIN = 9;
  typedef enum logic [1:0] {
    DRSCH_1X = 2'h0,
    DRSCH_2X = 2'h1,
    DRSCH_4X = 2'h2
  } drsch_mode_t;
  typedef enum logic [1:0] {
    DRSCH_T_NORM = 2'h0,
    DRSCH_T_HOT = 2'h1,
    DRSCH_T_VHOT = 2'h2,
    DRSCH_T_XHOT = 2'h3
  } drsch_temp_t;
  typedef enum logic [1:0] {
    DRSCH_S_IDLE = 2'h0,
    DRSCH_S_PRE = 2'h1,
    DRSCH_S_REF = 2'h3,
    DRSCH_S_HOLD = 2'h2
  } drsch_state_t;
endpackage

/* core/drsch_tick.sv */
`timescale 1ns/10ps
`default_nettype none
// Interval divider: one-cycle tick every period_cyc clocks
module drsch_tick #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [W-1:0] period_cyc,
  // Tick
  output logic tick
);
  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (count >= period_cyc - W'(1))
    begin
      count <= '0;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + W'(1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* core/drsch_win.sv */
`timescale 1ns/10ps
`default_nettype none
// Sliding window history: refreshes issued in each of the last DEPTH intervals.
// Small register array; read data registered.
module drsch_win #(
  parameter int DEPTH = 8,
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events
  input wire logic tick,
  input wire logic ref_pulse,
  input wire logic [3:0] win_len,
  // Result
  output logic [W-1:0] win_sum
);
  logic [W-1:0] slot [DEPTH];
  logic [W-1:0] next_sum;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
        slot[i] <= '0;
    end
    else if (tick)
    begin
      slot[0] <= ref_pulse ? W'(1) : '0;
      for (int i = 1; i < DEPTH; i++)
        slot[i] <= slot[i-1];
    end
    else if (ref_pulse)
      slot[0] <= slot[0] + W'(1);
  end

  always_comb
  begin
    next_sum = '0;
    for (int i = 0; i < DEPTH; i++)
      if (4'(i) < win_len)
        next_sum = next_sum + slot[i];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      win_sum <= '0;
    else
      win_sum <= next_sum;
  end
endmodule
`default_nettype wire

/* core/drsch_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Only deselects for refresh_cycle_time after refresh
// - Postpone at most 8/16/32 by mode
// - Gap at most 9/17/33 intervals
// - Pull in at most 8/16/32 by mode
// - Each early refresh lowers later debt
// - At most 16/32/64 refreshes per window
// - Untiered interval follows temperature band
// - thermal_refresh_enable selects temperature-controlled refresh
// - thermal_range_select picks normal or extended range
// - Program range to match operating conditions
// - Extended range spacing no more than 3.9us
// - 2x and 4x modes scale rate
// - Banks precharged for precharge time first
module drsch_ctrl #(
  parameter int RFC_CYC = drsch_pkg::RFC_8G_CYC,
  parameter int BASE_CYC = drsch_pkg::BASE_INTERVAL_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Software register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Command side towards the memory
  input wire logic banks_idle,
  output logic pre_all,
  output logic ref_cmd,
  output logic cmd_block,
  output logic thermal_refresh_enable,
  output logic thermal_range_select
);
  localparam int CW = drsch_pkg::CNT_W;
  localparam int DW = drsch_pkg::DEBT_W;

  // Window history spans the finest mode: eight quarter-rate intervals
  localparam int WIN_DEPTH = drsch_pkg::BURST_WIN_1X << drsch_pkg::DRSCH_4X;

  // Control register
  logic en;
  logic [1:0] mode;
  logic [1:0] temp;
  logic [1:0] dens;
  logic pullin;
  logic [31:0] ref_total;

  // Scheduling state
  drsch_pkg::drsch_state_t state;
  logic [1:0] mshift;
  logic [2:0] shift;
  logic [CW-1:0] period;
  logic [CW-1:0] rfc_cyc;
  logic [CW-1:0] pre_cnt;
  logic [CW-1:0] hold_cnt;
  logic [CW-1:0] since_ref;
  logic signed [DW-1:0] debt;
  logic signed [DW-1:0] post_lim;
  logic signed [DW-1:0] pull_lim;
  logic [DW-1:0] burst_lim;
  logic [3:0] win_len;
  logic [DW-1:0] win_sum;
  logic tick;
  logic owed;
  logic early;
  logic room;
  logic start;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      en <= 1'b0;
      mode <= drsch_pkg::DRSCH_1X;
      temp <= drsch_pkg::DRSCH_T_NORM;
      thermal_refresh_enable <= 1'b0;
      thermal_range_select <= 1'b0;
      dens <= 2'h2;
      pullin <= 1'b0;
    end
    else if (wr && addr == drsch_pkg::ADDR_CTRL)
    begin
      en <= wdata[drsch_pkg::CTRL_EN];
      mode <= wdata[drsch_pkg::CTRL_MODE_LO +: 2];
      temp <= wdata[drsch_pkg::CTRL_TEMP_LO +: 2];
      thermal_refresh_enable <= wdata[drsch_pkg::CTRL_TCR_EN];
      thermal_range_select <= wdata[drsch_pkg::CTRL_TCR_EXT];
      dens <= wdata[drsch_pkg::CTRL_DENS_LO +: 2];
      pullin <= wdata[drsch_pkg::CTRL_PULLIN];
    end
  end

  thermal_bits_a: assert property (
    wr && addr == drsch_pkg::ADDR_CTRL |=>
      thermal_refresh_enable == $past(wdata[drsch_pkg::CTRL_TCR_EN]) &&
      thermal_range_select == $past(wdata[drsch_pkg::CTRL_TCR_EXT]))
    else $error("thermal bits do not follow the control write");

  // Reserved mode code falls back to the finest granularity
  always_comb
  begin
    if (mode == 2'h3)
      mshift = 2'(drsch_pkg::DRSCH_4X);
    else
      mshift = mode;
  end

  // Temperature band and refresh mode both halve the interval per step.
  // Extended range keeps the external interval at half the base even when cool,
  // because the device does no skipping of its own in that range.
  always_comb
  begin
    if (thermal_refresh_enable && thermal_range_select &&
        temp == drsch_pkg::DRSCH_T_NORM)
      shift = 3'(mshift) + 3'h1;
    else
      shift = 3'(mshift) + 3'(temp);
  end

  assign period = CW'(BASE_CYC >> shift);

  ext_space_a: assert property (
    thermal_refresh_enable && thermal_range_select |-> period <= CW'(BASE_CYC >> 1))
    else $error("extended range interval too long");

  // Cycle time follows density; reserved code uses the largest part
  always_comb
  begin
    unique case (dens)
      2'h0:
        rfc_cyc = CW'(drsch_pkg::RFC_2G_CYC);
      2'h1:
        rfc_cyc = CW'(drsch_pkg::RFC_4G_CYC);
      default:
        rfc_cyc = CW'(RFC_CYC);
    endcase
  end

  // Limits scale with the refresh mode
  assign post_lim = DW'(drsch_pkg::POSTPONE_1X << mshift);
  assign pull_lim = DW'(drsch_pkg::PULLIN_1X << mshift);
  assign burst_lim = DW'(drsch_pkg::BURST_1X << mshift);
  assign win_len = 4'(drsch_pkg::BURST_WIN_1X << mshift);

  drsch_tick #(
    .W(CW)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .run(en),
    .period_cyc(period),
    .tick(tick)
  );

  drsch_win #(
    .DEPTH(WIN_DEPTH),
    .W(DW)
  ) u_win (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .ref_pulse(ref_cmd),
    .win_len(win_len),
    .win_sum(win_sum)
  );

  // Signed debt: positive means refreshes owed, negative means pulled in.
  // Disabling clears it, so a restart never inherits stale credit.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      debt <= '0;
    else if (!en)
      debt <= '0;
    else if (tick && !ref_cmd)
      debt <= debt + DW'(1);
    else if (ref_cmd && !tick)
      debt <= debt - DW'(1);
  end

  postpone_lim_a: assert property (
    debt <= post_lim)
    else $error("too many refreshes postponed");

  pullin_lim_a: assert property (
    debt >= -pull_lim)
    else $error("too many refreshes pulled in");

  assign owed = debt > DW'(0);
  assign early = pullin && (debt > -pull_lim);
  assign room = win_sum < burst_lim;
  assign start = en && room && (owed || early);

  // Sequence: precharge all, wait, refresh, then hold off for the cycle time
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= drsch_pkg::DRSCH_S_IDLE;
      pre_all <= 1'b0;
      ref_cmd <= 1'b0;
      cmd_block <= 1'b0;
    end
    else
    begin
      unique case (state)
        drsch_pkg::DRSCH_S_IDLE:
        begin
          if (start)
          begin
            state <= drsch_pkg::DRSCH_S_PRE;
            pre_all <= 1'b1;
          end
        end
        drsch_pkg::DRSCH_S_PRE:
        begin
          pre_all <= 1'b0;
          if (banks_idle && pre_cnt >= CW'(drsch_pkg::RP_CYC))
          begin
            state <= drsch_pkg::DRSCH_S_REF;
            ref_cmd <= 1'b1;
            cmd_block <= 1'b1;
          end
        end
        drsch_pkg::DRSCH_S_REF:
        begin
          ref_cmd <= 1'b0;
          state <= drsch_pkg::DRSCH_S_HOLD;
        end
        drsch_pkg::DRSCH_S_HOLD:
        begin
          if (hold_cnt == '0)
          begin
            state <= drsch_pkg::DRSCH_S_IDLE;
            cmd_block <= 1'b0;
          end
        end
      endcase
    end
  end

  // Banks may still report idle from before the precharge, so time it too
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pre_cnt <= '0;
    else if (state == drsch_pkg::DRSCH_S_IDLE)
      pre_cnt <= '0;
    else if (state == drsch_pkg::DRSCH_S_PRE && pre_cnt != '1)
      pre_cnt <= pre_cnt + CW'(1);
  end

  precharge_wait_a: assert property (
    ref_cmd |-> banks_idle && pre_cnt >= CW'(drsch_pkg::RP_CYC))
    else $error("refresh before precharge settled");

  // Refresh cycle plus hold together last exactly rfc_cyc cycles
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hold_cnt <= '0;
    else if (state == drsch_pkg::DRSCH_S_REF)
      hold_cnt <= rfc_cyc - CW'(2);
    else if (state == drsch_pkg::DRSCH_S_HOLD && hold_cnt != '0)
      hold_cnt <= hold_cnt - CW'(1);
  end

  // Saturating age of the last refresh, for the spacing check
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      since_ref <= '1;
    else if (ref_cmd)
      since_ref <= CW'(1);
    else if (since_ref != '1)
      since_ref <= since_ref + CW'(1);
  end

  rfc_gap_a: assert property (
    ref_cmd |-> since_ref >= rfc_cyc)
    else $error("refresh inside refresh cycle time");

  desel_hold_a: assert property (
    cmd_block |-> !pre_all)
    else $error("command issued during refresh cycle");

  burst_lim_a: assert property (
    ref_cmd |-> win_sum < burst_lim)
    else $error("refresh burst limit exceeded");

  cov_pullin_c: cover property (ref_cmd && pullin && debt <= DW'(0));
  cov_fine_c: cover property (ref_cmd && mshift == 2'(drsch_pkg::DRSCH_4X));
  cov_ext_c: cover property (ref_cmd && thermal_refresh_enable && thermal_range_select);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ref_total <= '0;
    else if (ref_cmd)
      ref_total <= ref_total + 32'h1;
  end

  // Status views for software
  assign ctrl_word = {22'h0, pullin, dens, thermal_range_select, thermal_refresh_enable,
    temp, mode, en};
  assign stat_word = {16'h0, debt, 6'h0, state};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= '0;
    else if (rd)
    begin
      unique case (addr)
        drsch_pkg::ADDR_CTRL:
          rdata <= ctrl_word;
        drsch_pkg::ADDR_STAT:
          rdata <= stat_word;
        drsch_pkg::ADDR_COUNT:
          rdata <= ref_total;
        default:
          rdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* verif/drsch_dev.sv */
`timescale 1ns/10ps
`default_nettype none
// Device side: precharge settling and internal refresh skipping
module drsch_dev #(
  parameter int RP = drsch_pkg::RP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Commands
  input wire logic pre_all,
  input wire logic ref_cmd,
  input wire logic tcr_en,
  input wire logic tcr_ext,
  // Status
  output logic banks_idle,
  output logic [15:0] ref_int
);
  logic [3:0] rp_cnt;
  logic gear;
  assign banks_idle = (rp_cnt == 4'h0);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rp_cnt <= 4'hF;
    else if (pre_all)
      rp_cnt <= 4'(RP);
    else if (rp_cnt != 4'h0)
      rp_cnt <= rp_cnt - 4'h1;
  // Every refresh is registered; with the thermal mode on in normal range every other one is skipped
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      gear <= 1'b0;
      ref_int <= 16'h0;
    end
    else if (ref_cmd)
    begin
      gear <= tcr_en ? ~gear : 1'b0;
      if (!(tcr_en && gear && !tcr_ext))
        ref_int <= ref_int + 16'h1;
    end
endmodule
`default_nettype wire

/* verif/tb_drsch_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb_drsch_ctrl;
  localparam int BASE = 160;
  localparam int RFC = 6;
  localparam logic [31:0] DENS = 32'h2 << drsch_pkg::CTRL_DENS_LO;
  localparam logic [31:0] EN = 32'h1 << drsch_pkg::CTRL_EN;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, idle, pre, rf, blk, ten, tex;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] ri;
  int fail_count, n_checks, cyc, g, nref, n0;
  drsch_ctrl #(.RFC_CYC(RFC), .BASE_CYC(BASE)) u_dut (.clk(clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .banks_idle(idle),
    .pre_all(pre), .ref_cmd(rf), .cmd_block(blk), .thermal_refresh_enable(ten),
    .thermal_range_select(tex));
  drsch_dev #(.RP(4)) u_dev (.clk(clk), .rstn(rstn), .pre_all(pre), .ref_cmd(rf),
    .tcr_en(ten), .tcr_ext(tex), .banks_idle(idle), .ref_int(ri));
  initial forever #2 clk = ~clk;
  always @(posedge clk)
    if (rf === 1'b1)
      nref++;
  always @(posedge clk)
    if (++cyc > 20000)
    begin
      fail_count++;
      print_verdict();
    end
  task automatic wr_ctrl(input logic [31:0] d);
    @(posedge clk);
    addr <= drsch_pkg::ADDR_CTRL;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_ref(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rf !== 1'b1 && n < 3000);
  endtask
  task automatic test_thermal();
    for (int i = 0; i < 4; i++)
    begin
      wr_ctrl(32'(i) << drsch_pkg::CTRL_TCR_EN);
      repeat (2) @(posedge clk);
      `CHK(ten, i[0])
      `CHK(tex, i[1])
    end
    $display("test thermal done");
  endtask
  task automatic test_ref();
    for (int m = 0; m < 3; m++)
    begin
      wr_ctrl(EN | DENS | (32'(m) << drsch_pkg::CTRL_MODE_LO));
      repeat (3)
        wait_ref(g);
      `CHK(g <= ((8 << m) + 1) * BASE >> m, 1'b1)
      wait_ref(g);
      `CHK(g, BASE >> m)
      `CHK(idle, 1'b1)
      repeat (RFC - 1)
      begin
        @(posedge clk);
        `CHK(rf, 1'b0)
        `CHK(blk, 1'b1)
      end
      @(posedge clk);
      `CHK(blk, 1'b0)
    end
    $display("test refresh done");
  endtask
  task automatic run_gap(input logic [31:0] cfg, output int n);
    wr_ctrl(EN | DENS | cfg);
    repeat (4)
      wait_ref(n);
  endtask
  task automatic test_temp();
    run_gap(32'h1 << drsch_pkg::CTRL_TEMP_LO, g);
    `CHK(g, BASE >> 1)
    run_gap(32'h3 << drsch_pkg::CTRL_TCR_EN, g);
    `CHK(g, BASE >> 1)
    run_gap(32'h1 << drsch_pkg::CTRL_TCR_EN, g);
    `CHK(g, BASE)
    $display("test temperature done");
  endtask
  task automatic test_pullin();
    wr_ctrl(DENS);
    repeat (40) @(posedge clk);
    n0 = nref;
    wr_ctrl(EN | DENS | (32'h1 << drsch_pkg::CTRL_PULLIN));
    repeat (130) @(posedge clk);
    `CHK(nref - n0, drsch_pkg::PULLIN_1X)
    rd_reg(drsch_pkg::ADDR_STAT, d);
    `CHK(d[15:8], 8'(-drsch_pkg::PULLIN_1X))
    wr_ctrl(DENS);
    repeat (40) @(posedge clk);
    rd_reg(drsch_pkg::ADDR_COUNT, d);
    `CHK(d, 32'(nref))
    $display("test pull-in done");
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    test_thermal();
    test_ref();
    test_temp();
    test_pullin();
    print_verdict();
  end
endmodule
`default_nettype wire
